/* File: include/ssld_defs.vh */
// constants for the serial-in latched sink driver
// assumes a single system clock; device pins are sampled through synchronisers
`ifndef SSLD_DEFS_VH
`define SSLD_DEFS_VH
`define SSLD_WIDTH      16
`define SSLD_MSB        15
`define SSLD_SYNC_DEPTH 2
`define SSLD_ALL_OFF    16'hFFFF
`define SSLD_ZERO16     16'h0000
`define SSLD_FIRST      0
`define SSLD_PIN_COUNT  4
`define SSLD_PIN_MSB    3
`define SSLD_PIN_DATA   3
`define SSLD_PIN_SCLK   2
`define SSLD_PIN_STROBE 1
`define SSLD_PIN_OEN    0
`endif

/* File: verif/ssld_asserts.sv */
// pin checks for ssld_driver; clk_en assumed high
`timescale 1ns/1ps
module ssld_asserts (
  input wire logic        clk, reset_n, serial_in, shift_clk,
  input wire logic        latch_strobe, output_enable_n, serial_out,
  input wire logic [15:0] sink_outputs
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_reset_blank: assert property ($rose(reset_n) |->
    sink_outputs == 16'hFFFF && !serial_out) else $error("reset");
  a_blank_all: assert property (output_enable_n[*5] |->
    sink_outputs == 16'hFFFF) else $error("blank");
  a_blank_fast: assert property ($rose(output_enable_n) |->
    ##[1:5] sink_outputs == 16'hFFFF) else $error("blank late");
  a_latch_hold: assert property ((!latch_strobe && !output_enable_n)[*6]
    |-> $stable(sink_outputs)) else $error("latch moved");
  a_no_edge_hold: assert property ((!shift_clk && !output_enable_n
    && latch_strobe)[*6] |-> $stable(sink_outputs)) else $error("drift");
  a_sout_hold: assert property ((!shift_clk)[*6]
    |-> $stable(serial_out)) else $error("serial moved");
  a_tail_match: assert property ((latch_strobe && !output_enable_n)[*6]
    |-> serial_out != sink_outputs[15]) else $error("tail");
  a_first_stage: assert property ($rose(shift_clk) && serial_in
    && latch_strobe && !output_enable_n |-> ##[1:5] !sink_outputs[0])
    else $error("stage one");
endmodule // ssld_asserts
bind ssld_driver ssld_asserts ssld_asserts_i (.*);

/* File: verif/ssld_ctrl_model.sv */
// controller model driving the pins, blanked until loaded
`timescale 1ns/1ps
module ssld_ctrl_model (
  input  wire clk,
  output reg  serial_in, shift_clk, latch_strobe, output_enable_n
);
  initial {serial_in, shift_clk, latch_strobe, output_enable_n} = 4'h1;
  task tick(input int n); repeat (n) @(posedge clk); endtask
  task pins(input logic s, e);
    latch_strobe <= s;
    output_enable_n <= e;
    tick(5);
  endtask
  task send(input logic [15:0] w);
    for (int i = 15; i >= 0; i--)
    begin
      serial_in <= w[i];
      tick(3);
      shift_clk <= 1'b1;
      tick(3);
      shift_clk <= 1'b0;
    end
    serial_in <= ~w[0];
    tick(3);
  endtask
endmodule // ssld_ctrl_model

/* File: verif/testbench.sv */
// word table through the controller model, then hold and blank cases
`timescale 1ns/1ps
module testbench;
  logic        clk;
  logic        reset_n;
  logic        clk_en = 1'b1;
  wire         serial_in, shift_clk, latch_strobe, output_enable_n;
  wire         serial_out;
  wire  [15:0] sink_outputs;
  logic [31:0] rows [4] = '{32'hA5C3_5A3C, 32'h0001_FFFE, 32'h8000_7FFF,
                            32'hFFFF_0000};
  int          error_cnt = 0;
  int          tests_run = 0;
  ssld_driver ssld_driver_i (.clk, .reset_n, .clk_en, .serial_in,
    .shift_clk, .latch_strobe, .output_enable_n, .sink_outputs, .serial_out);
  ssld_ctrl_model ssld_ctrl_model_i (.clk, .serial_in, .shift_clk,
    .latch_strobe, .output_enable_n);
  task chk(input logic [15:0] g, e);
    tests_run++;
    if (g !== e) error_cnt++;
    if (g !== e) $display("Error at %0t: got %h exp %h", $time, g, e);
  endtask
  task finish_test;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    reset_n = 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    chk(sink_outputs, 16'hFFFF);
    foreach (rows[i])
    begin
      ssld_ctrl_model_i.send(rows[i][31:16]);
      ssld_ctrl_model_i.pins(1'b1, 1'b0);
      ssld_ctrl_model_i.pins(1'b0, 1'b0);
      chk(sink_outputs, rows[i][15:0]);
      chk(16'(serial_out), 16'(rows[i][31]));
    end
    ssld_ctrl_model_i.pins(1'b0, 1'b1);
    chk(sink_outputs, 16'hFFFF);
    ssld_ctrl_model_i.send(16'h1234);
    ssld_ctrl_model_i.pins(1'b0, 1'b0);
    chk(sink_outputs, 16'h0000);
    ssld_ctrl_model_i.pins(1'b1, 1'b0);
    ssld_ctrl_model_i.send(16'h8001);
    chk(sink_outputs, 16'h7FFE);
    clk_en <= 1'b0;
    ssld_ctrl_model_i.send(16'h0000);
    clk_en <= 1'b1;
    ssld_ctrl_model_i.pins(1'b1, 1'b0);
    chk(sink_outputs, 16'h7FFE);
    finish_test;
  end
endmodule // testbench

/* File: verilog/ssld_driver.v */
// serial-in latched sink driver: shift register, latch, blanked sinks
// assumes the pins are asynchronous to clk and clk is far faster than
// the shift clock; reset_n is a system reset, the part itself has none
`timescale 1ns/1ps
`include "ssld_defs.vh"
module ssld_driver (
  // system
  input  wire                   clk,
  input  wire                   reset_n,
  input  wire                   clk_en,
  // controller pins
  input  wire                   serial_in,
  input  wire                   shift_clk,
  input  wire                   latch_strobe,
  input  wire                   output_enable_n,
  // device outputs
  output reg  [`SSLD_MSB:0]     sink_outputs,
  output reg                    serial_out
);
  // synchronised copies of the four controller pins
  wire [`SSLD_PIN_MSB:0] pins_s;
  wire                   data_s;
  wire                   sclk_s;
  wire                   strobe_s;
  wire                   oe_n_s;

  // edge detection on the shift clock
  reg                    shift_clk_prev_q;
  wire                   shift_clk_prev_d;
  wire                   shift_edge;

  // storage: shift stages and their holding latch bits
  reg  [`SSLD_MSB:0]     shift_q;
  wire [`SSLD_MSB:0]     shift_d;
  reg  [`SSLD_MSB:0]     latch_q;
  wire [`SSLD_MSB:0]     latch_d;

  // next values of the registered outputs
  wire [`SSLD_MSB:0]     sink_d;
  wire                   serial_out_d;

  // one pin level per sink: low sinks current, high is off.
  // blanking wins over the latch bit so the latch is never disturbed
  function sink_level;
    input oe_n;
    input bit_on;
    begin
      sink_level = oe_n | ~bit_on;
    end
  endfunction

  // every pin is asynchronous: two flops before any logic reads it
  ssld_sync #(
    .W (`SSLD_PIN_COUNT)
  ) u_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .clk_en   (clk_en),
    .async_in ({serial_in, shift_clk, latch_strobe, output_enable_n}),
    .sync_out (pins_s)
  );

  assign data_s   = pins_s[`SSLD_PIN_DATA];
  assign sclk_s   = pins_s[`SSLD_PIN_SCLK];
  assign strobe_s = pins_s[`SSLD_PIN_STROBE];
  assign oe_n_s   = pins_s[`SSLD_PIN_OEN];

  // edge seen on the synchronised copy only; the previous-value flop
  // resets low, matching the idle level of the shift clock pin, so no
  // false edge appears just after reset
  assign shift_clk_prev_d = sclk_s;
  assign shift_edge       = sclk_s & ~shift_clk_prev_q;

  // shift stages: stage one takes the data pin, each later stage takes
  // its neighbour. data is synchronised alongside the clock, so pin
  // setup and hold carry through to the sampling point
  genvar gi;
  generate
    for (gi = `SSLD_FIRST; gi <= `SSLD_MSB; gi = gi + 1)
    begin : g_stage
      if (gi == `SSLD_FIRST)
      begin : g_head
        assign shift_d[gi] = shift_edge ? data_s
                                        : shift_q[gi];
      end
      else
      begin : g_body
        assign shift_d[gi] = shift_edge ? shift_q[gi - 1]
                                        : shift_q[gi];
      end
    end
  endgenerate

  // holding latch: transparent while strobe high, so a new shift value
  // flows straight through; strobe low keeps the old bit whatever the
  // shift register does. the enable pin never enters here
  generate
    for (gi = `SSLD_FIRST; gi <= `SSLD_MSB; gi = gi + 1)
    begin : g_latch
      assign latch_d[gi] = strobe_s ? shift_d[gi]
                                    : latch_q[gi];
    end
  endgenerate

  // sink drivers: one per latch bit, all blanked together by enable
  generate
    for (gi = `SSLD_FIRST; gi <= `SSLD_MSB; gi = gi + 1)
    begin : g_sink
      assign sink_d[gi] = sink_level(oe_n_s,
                                     latch_d[gi]);
    end
  endgenerate

  // chain output shows the last stage as it will stand after this edge
  assign serial_out_d = shift_d[`SSLD_MSB];

  // edge detector register
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      shift_clk_prev_q <= 1'b0;
    end
    else if (clk_en)
    begin
      shift_clk_prev_q <= shift_clk_prev_d;
    end
  end

  // shift register; the real part has no reset, zero is a chosen start
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      shift_q <= `SSLD_ZERO16;
    end
    else if (clk_en)
    begin
      shift_q <= shift_d;
    end
  end

  // holding latch, built as a register clocked by clk; it loads shift_d, so it adds no
  // clk of delay against a true level latch and keeps the block single-clock
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      latch_q <= `SSLD_ZERO16;
    end
    else if (clk_en)
    begin
      latch_q <= latch_d;
    end
  end

  // registered outputs: sinks start blanked, chain output low
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sink_outputs <= `SSLD_ALL_OFF;
      serial_out   <= 1'b0;
    end
    else if (clk_en)
    begin
      sink_outputs <= sink_d;
      serial_out   <= serial_out_d;
    end
  end

  // limitation: pin pulses shorter than one clk period may be missed;
  // the controller must hold each shift clock phase for three or more
endmodule // ssld_driver

/* File: verilog/ssld_sync.v */
// two-stage synchroniser for a group of asynchronous pin levels
// assumes inputs come from outside the clk domain
`timescale 1ns/1ps
`include "ssld_defs.vh"
module ssld_sync #(
  parameter W = 4
) (
  // clocking
  input  wire         clk,
  input  wire         reset_n,
  input  wire         clk_en,
  // levels
  input  wire [W-1:0] async_in,
  output reg  [W-1:0] sync_out
);
  reg [W-1:0] meta_q;

  // first stage is read only by the second
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_q   <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end
    else if (clk_en)
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // ssld_sync
